// ### src/dfm_mode_capture.sv
// Captures the operating mode from synchronised strap levels once after reset.
// Assumes strap inputs already passed a two-flop synchroniser on clk.
`timescale 1ns/100ps
`default_nettype none
module dfm_mode_capture
    import dfm_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic primary_s,
    input  wire logic secondary_s,
    input  wire logic boot0_s,
    input  wire logic boot1_s,
    output dfm_mode_e mode
);
    logic [1:0] wait_cnt;
    logic [1:0] next_wait_cnt;
    dfm_mode_e  next_mode;

    // Synchroniser holds reset zeros for two edges, so wait before sampling
    always_comb begin
        next_wait_cnt = wait_cnt;
        next_mode     = mode;
        if (mode == MODE_PEND) begin
            if (wait_cnt == MODE_SAMPLE_CYC)
                next_mode = dfm_decode_mode(primary_s, secondary_s, boot0_s, boot1_s);
            else
                next_wait_cnt = wait_cnt + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= 2'h0;
            mode     <= MODE_PEND;
        end else begin
            wait_cnt <= next_wait_cnt;
            mode     <= next_mode;
        end
    end
endmodule // dfm_mode_capture
`default_nettype wire

// ### src/dfm_pin_mux.sv
// Debug port group pin mux with strap mode decode and AHB-Lite registers.
// Assumes an on-chip debug/programming engine on hclk drives the tool side,
// a port controller drives the GPIO side, and pad cells resolve out/oe.
//
// Summary of operation
// - Mode comes from the straps: primary low is normal, primary high with secondary low is flash programming, both high with boot select 0 low and 1 high is boundary scan.
// - Normal mode runs application software and still allows the debug interfaces.
// - Flash programming mode hands the flash program and erase path to the external tool.
// - Boundary scan mode runs no application and no tool interface, only scan test.
// - One-pin debug claims only bit 0 as a bidirectional line with no software set-up, bits 1 to 6 stay GPIO.
// - Four-pin debug uses bit 0 data in, bit 1 data out, bit 2 clock in and bit 5 clock out.
// - Nexus debug claims all seven bits: data in, data out, clock, mode select, reset, ready out and event.
// - Bits not claimed by the active debug interface keep their GPIO and alternate behaviour.
// - One-wire UART programming exchanges data half-duplex on bit 0 only.
// - Two-wire UART programming receives on bit 0 and transmits on bit 1.
// - Clocked serial programming takes data in on bit 0, sends on bit 1, clocked by bit 2.
`timescale 1ns/100ps
`default_nettype none
module dfm_pin_mux
    import dfm_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    // Mode straps
    input  wire logic              primary_flash_mode_pin,
    input  wire logic              secondary_flash_mode_pin,
    input  wire logic              boot_select_0,
    input  wire logic              boot_select_1,
    // Debug port group pads
    input  wire logic [PINS-1:0]   dbg_pin_in,
    output logic      [PINS-1:0]   dbg_pin_out,
    output logic      [PINS-1:0]   dbg_pin_oe,
    // Port controller side
    input  wire logic [PINS-1:0]   gpio_out,
    input  wire logic [PINS-1:0]   gpio_oe,
    output logic      [PINS-1:0]   gpio_in,
    // Debug and programming engine side
    input  wire logic [2:0]        tool_select,
    input  wire logic              eng_data_out,
    input  wire logic              eng_data_oe,
    input  wire logic              eng_clk_out,
    input  wire logic              eng_ready,
    input  wire logic              eng_event,
    output logic                   eng_data_in,
    output logic                   eng_clk,
    output logic                   eng_clk_rise,
    output logic                   eng_tms,
    output logic                   eng_trst,
    output logic                   run_app,
    output logic                   flash_prog_en,
    output logic                   bscan_en,
    output logic [6:0]             active_if
);
    logic [PINS-1:0] pin_s;
    logic [3:0]      strap_s;
    dfm_mode_e       mode;

    // Strap pins share pads with port functions, so they are synchronised too
    dfm_sync #(.WIDTH(PINS)) u_pin_sync (
        .clk      (hclk),
        .rst_n    (hresetn),
        .async_in (dbg_pin_in),
        .sync_out (pin_s)
    );

    dfm_sync #(.WIDTH(4)) u_strap_sync (
        .clk      (hclk),
        .rst_n    (hresetn),
        .async_in ({boot_select_1, boot_select_0,
                    secondary_flash_mode_pin, primary_flash_mode_pin}),
        .sync_out (strap_s)
    );

    // Straps rely on the tool keeping the secondary pin low at release
    dfm_mode_capture u_mode (
        .clk         (hclk),
        .rst_n       (hresetn),
        .primary_s   (strap_s[0]),
        .secondary_s (strap_s[1]),
        .boot0_s     (strap_s[2]),
        .boot1_s     (strap_s[3]),
        .mode        (mode)
    );

    // ---------------- AHB-Lite register slave ----------------
    logic        dbg_en;
    logic        wr_pend;
    logic [31:0] wr_addr;
    logic        next_dbg_en;
    logic        next_wr_pend;
    logic [31:0] next_wr_addr;
    logic [31:0] next_hrdata;
    logic        take;
    dfm_if_e     active;

    assign take = hsel && hready && htrans[1];

    always_comb begin
        next_dbg_en  = dbg_en;
        next_wr_pend = take && hwrite;
        next_wr_addr = take ? haddr : wr_addr;
        next_hrdata  = 32'h0000_0000;
        if (wr_pend && wr_addr == CTRL_OFS)
            next_dbg_en = hwdata[CTRL_DBG_EN_BIT];
        if (take && !hwrite) begin
            if (haddr == CTRL_OFS)
                next_hrdata[CTRL_DBG_EN_BIT] = dbg_en;
            else if (haddr == STAT_OFS) begin
                next_hrdata[STAT_MODE_LSB +: 5] = mode;
                next_hrdata[STAT_IF_LSB +: 7]   = active;
                next_hrdata[STAT_PIN_LSB +: PINS] = pin_s;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbg_en    <= CTRL_DBG_EN_RST;
            wr_pend   <= 1'b0;
            wr_addr   <= 32'h0000_0000;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            dbg_en    <= next_dbg_en;
            wr_pend   <= next_wr_pend;
            wr_addr   <= next_wr_addr;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ---------------- Interface selection ----------------
    dfm_if_e next_active;
    logic    next_run_app;
    logic    next_flash_prog_en;
    logic    next_bscan_en;

    // Debug engine picks the interface; debug is enabled out of reset
    always_comb begin
        next_active        = dfm_if_pick(mode, tool_select, dbg_en);
        next_run_app       = (mode == MODE_NORMAL);
        next_flash_prog_en = (mode == MODE_FLASH);
        next_bscan_en      = (mode == MODE_BSCAN);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active        <= IF_NONE;
            run_app       <= 1'b0;
            flash_prog_en <= 1'b0;
            bscan_en      <= 1'b0;
        end else begin
            active        <= next_active;
            run_app       <= next_run_app;
            flash_prog_en <= next_flash_prog_en;
            bscan_en      <= next_bscan_en;
        end
    end

    assign active_if = active;

    // ---------------- Pin mux ----------------
    logic [PINS-1:0] next_pin_out;
    logic [PINS-1:0] next_pin_oe;
    logic [PINS-1:0] next_gpio_in;
    logic            next_eng_data_in;
    logic            next_eng_clk;
    logic            next_eng_tms;
    logic            next_eng_trst;
    logic            clk_claimed;

    always_comb begin
        next_pin_out     = gpio_out;
        next_pin_oe      = gpio_oe;
        next_gpio_in     = pin_s;
        next_eng_data_in = 1'b0;
        next_eng_tms     = 1'b0;
        next_eng_trst    = 1'b0;
        clk_claimed      = 1'b0;
        case (active)
            IF_LPD1, IF_UART1: begin
                next_pin_out[PIN_DATA] = eng_data_out;
                next_pin_oe[PIN_DATA]  = eng_data_oe;
                next_gpio_in[PIN_DATA] = 1'b0;
            end
            IF_LPD4: begin
                next_pin_out[PIN_DATA] = 1'b0;
                next_pin_oe[PIN_DATA]  = 1'b0;
                next_pin_out[PIN_TX]   = eng_data_out;
                next_pin_oe[PIN_TX]    = 1'b1;
                next_pin_out[PIN_CLK]  = 1'b0;
                next_pin_oe[PIN_CLK]   = 1'b0;
                next_pin_out[PIN_CLKO] = eng_clk_out;
                next_pin_oe[PIN_CLKO]  = 1'b1;
                next_gpio_in[PIN_DATA] = 1'b0;
                next_gpio_in[PIN_TX]   = 1'b0;
                next_gpio_in[PIN_CLK]  = 1'b0;
                next_gpio_in[PIN_CLKO] = 1'b0;
                clk_claimed            = 1'b1;
            end
            IF_NEXUS: begin
                next_pin_out           = '0;
                next_pin_oe            = '0;
                next_gpio_in           = '0;
                next_pin_out[PIN_TX]   = eng_data_out;
                next_pin_oe[PIN_TX]    = 1'b1;
                next_pin_out[PIN_CLKO] = eng_ready;
                next_pin_oe[PIN_CLKO]  = 1'b1;
                next_pin_out[PIN_EVT]  = eng_event;
                next_pin_oe[PIN_EVT]   = 1'b1;
                next_eng_tms           = pin_s[PIN_TMS];
                next_eng_trst          = pin_s[PIN_TRST];
                clk_claimed            = 1'b1;
            end
            IF_UART2, IF_CSI: begin
                next_pin_out[PIN_DATA] = 1'b0;
                next_pin_oe[PIN_DATA]  = 1'b0;
                next_pin_out[PIN_TX]   = eng_data_out;
                next_pin_oe[PIN_TX]    = 1'b1;
                next_gpio_in[PIN_DATA] = 1'b0;
                next_gpio_in[PIN_TX]   = 1'b0;
                if (active == IF_CSI) begin
                    next_pin_out[PIN_CLK] = 1'b0;
                    next_pin_oe[PIN_CLK]  = 1'b0;
                    next_gpio_in[PIN_CLK] = 1'b0;
                    clk_claimed           = 1'b1;
                end
            end
            default: begin
            end
        endcase
        if (active != IF_NONE)
            next_eng_data_in = pin_s[PIN_DATA];
        // Tool clock is sampled, so it must stay well under half of hclk
        next_eng_clk = clk_claimed & pin_s[PIN_CLK];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbg_pin_out  <= '0;
            dbg_pin_oe   <= '0;
            gpio_in      <= '0;
            eng_data_in  <= 1'b0;
            eng_clk      <= 1'b0;
            eng_clk_rise <= 1'b0;
            eng_tms      <= 1'b0;
            eng_trst     <= 1'b0;
        end else begin
            dbg_pin_out  <= next_pin_out;
            dbg_pin_oe   <= next_pin_oe;
            gpio_in      <= next_gpio_in;
            eng_data_in  <= next_eng_data_in;
            eng_clk      <= next_eng_clk;
            eng_clk_rise <= next_eng_clk & ~eng_clk;
            eng_tms      <= next_eng_tms;
            eng_trst     <= next_eng_trst;
        end
    end
endmodule // dfm_pin_mux
`default_nettype wire

// ### src/dfm_pkg.sv
// Constants, types and decode functions for the debug and flash mode pin mux.
// Assumes a single 20 MHz clock domain for all register and mux logic.
package dfm_pkg;

    // Debug port group width and bit roles
    localparam int PINS     = 7;
    localparam int PIN_DATA = 0;
    localparam int PIN_TX   = 1;
    localparam int PIN_CLK  = 2;
    localparam int PIN_TMS  = 3;
    localparam int PIN_TRST = 4;
    localparam int PIN_CLKO = 5;
    localparam int PIN_EVT  = 6;

    // Register map (byte addresses)
    localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
    localparam logic [31:0] STAT_OFS = 32'h0000_0004;

    // Field positions and reset values
    localparam int   CTRL_DBG_EN_BIT = 0;
    localparam logic CTRL_DBG_EN_RST = 1'b1;
    localparam int   STAT_MODE_LSB   = 0;
    localparam int   STAT_IF_LSB     = 8;
    localparam int   STAT_PIN_LSB    = 16;

    // Cycles after reset release before the synchronised straps are valid
    localparam logic [1:0] MODE_SAMPLE_CYC = 2'h2;

    // Tool interface request codes from the on-chip debug unit
    localparam logic [2:0] TSEL_NONE  = 3'h0;
    localparam logic [2:0] TSEL_LPD1  = 3'h1;
    localparam logic [2:0] TSEL_LPD4  = 3'h2;
    localparam logic [2:0] TSEL_NEXUS = 3'h3;
    localparam logic [2:0] TSEL_UART1 = 3'h4;
    localparam logic [2:0] TSEL_UART2 = 3'h5;
    localparam logic [2:0] TSEL_CSI   = 3'h6;

    typedef enum logic [4:0] {
        MODE_PEND   = 5'h01,
        MODE_NORMAL = 5'h02,
        MODE_FLASH  = 5'h04,
        MODE_BSCAN  = 5'h08,
        MODE_RSVD   = 5'h10
    } dfm_mode_e;

    typedef enum logic [6:0] {
        IF_NONE  = 7'h01,
        IF_LPD1  = 7'h02,
        IF_LPD4  = 7'h04,
        IF_NEXUS = 7'h08,
        IF_UART1 = 7'h10,
        IF_UART2 = 7'h20,
        IF_CSI   = 7'h40
    } dfm_if_e;

    function automatic dfm_mode_e dfm_decode_mode(input logic primary,
                                                  input logic secondary,
                                                  input logic boot0,
                                                  input logic boot1);
        if (!primary)
            return MODE_NORMAL;
        else if (!secondary)
            return MODE_FLASH;
        else if (!boot0 && boot1)
            return MODE_BSCAN;
        else
            return MODE_RSVD;
    endfunction

    function automatic dfm_if_e dfm_if_pick(input dfm_mode_e mode,
                                            input logic [2:0] tsel,
                                            input logic dbg_en);
        dfm_if_e pick;
        pick = IF_NONE;
        if (mode == MODE_NORMAL && dbg_en) begin
            case (tsel)
                TSEL_LPD1:  pick = IF_LPD1;
                TSEL_LPD4:  pick = IF_LPD4;
                TSEL_NEXUS: pick = IF_NEXUS;
                default:    pick = IF_NONE;
            endcase
        end else if (mode == MODE_FLASH) begin
            case (tsel)
                TSEL_UART1: pick = IF_UART1;
                TSEL_UART2: pick = IF_UART2;
                TSEL_CSI:   pick = IF_CSI;
                default:    pick = IF_NONE;
            endcase
        end
        return pick;
    endfunction

endpackage

// ### src/dfm_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to clk; only the second stage is read.
`timescale 1ns/100ps
`default_nettype none
module dfm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // dfm_sync
`default_nettype wire

// ### tb/dfm_pin_mux_props.sv
// Checker for the debug port pin mux, bound to the top module ports.
// Assumes one hclk domain and a pin map that follows active_if by one edge.
`timescale 1ns/100ps
`default_nettype none
module dfm_pin_mux_props (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic [6:0] dbg_pin_in,
    input wire logic [6:0] dbg_pin_out,
    input wire logic [6:0] dbg_pin_oe,
    input wire logic       eng_data_out,
    input wire logic       eng_data_oe,
    input wire logic       eng_ready,
    input wire logic       eng_event,
    input wire logic       eng_data_in,
    input wire logic       run_app,
    input wire logic       flash_prog_en,
    input wire logic       bscan_en,
    input wire logic [6:0] active_if
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic [2:0] mode_bits = {run_app, flash_prog_en, bscan_en};
    // Pad pipeline is three deep, so the interface must have stood that long
    sequence s_if_held;
        (active_if != 7'h01)[*3];
    endsequence
    sequence s_map4;
        dbg_pin_oe[1] && dbg_pin_oe[5] && !dbg_pin_oe[0] && !dbg_pin_oe[2];
    endsequence
    a_mode_onehot: assert property ($onehot0(mode_bits))
        else $error("mode outputs overlap");
    a_dbg_normal: assert property (active_if inside {7'h02, 7'h04, 7'h08} |-> run_app)
        else $error("debug interface outside normal mode");
    a_prog_flash: assert property (active_if[6:4] != 3'h0 |-> flash_prog_en)
        else $error("programming interface outside flash mode");
    a_bscan_idle: assert property (bscan_en |-> active_if == 7'h01)
        else $error("tool interface in scan mode");
    a_mode_held: assert property (mode_bits != 3'h0 |=> $stable(mode_bits))
        else $error("mode changed without reset");
    a_bit0_drive: assert property (active_if inside {7'h02, 7'h10} |=>
        dbg_pin_out[0] == $past(eng_data_out) && dbg_pin_oe[0] == $past(eng_data_oe))
        else $error("bit 0 not driven by engine");
    a_map_four: assert property (active_if == 7'h04 |=> s_map4)
        else $error("four pin map wrong");
    a_nexus_map: assert property (active_if == 7'h08 |=> dbg_pin_oe == 7'h62
        && dbg_pin_out[5] == $past(eng_ready) && dbg_pin_out[6] == $past(eng_event))
        else $error("nexus map wrong");
    a_serial_map: assert property (active_if inside {7'h20, 7'h40} |=>
        dbg_pin_oe[1:0] == 2'b10 && dbg_pin_out[1] == $past(eng_data_out))
        else $error("serial programming map wrong");
    a_data_in: assert property (s_if_held |-> eng_data_in == $past(dbg_pin_in[0], 3))
        else $error("bit 0 level not passed to engine");
endmodule // dfm_pin_mux_props
`default_nettype wire

// ### tb/dfm_pin_mux_test.sv
// Self-checking bench for the debug port pin mux and a behavioural tool.
// Assumes a 50 ns hclk and board pull-ups on every debug pad.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end
module dfm_pin_mux_test;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0, strap_sel = 2'h0;
    logic [2:0]  hsize = 3'h2, tool_select = 3'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
    logic        hreadyout, hresp, hready, go = 1'b0, framing = 1'b0, busy;
    logic        primary_flash_mode_pin, secondary_flash_mode_pin, boot_select_0, boot_select_1;
    logic [6:0]  dbg_pin_in, dbg_pin_out, dbg_pin_oe, gpio_in, tool_out, tool_oe, active_if;
    logic [6:0]  gpio_out = 7'h7F, gpio_oe = 7'h00;
    logic        eng_data_out = 1'b0, eng_data_oe = 1'b1, eng_clk_out = 1'b0;
    logic        eng_ready = 1'b1, eng_event = 1'b0;
    logic        eng_data_in, eng_clk, eng_clk_rise, eng_tms, eng_trst;
    logic        run_app, flash_prog_en, bscan_en;
    logic [7:0]  tx_byte = 8'h00, rx_byte, got = 8'h00;
    int          err_total = 0, checks_done = 0, rises = 0;
    // Flash strap, tool select, active_if, pad enables, pad outputs
    logic [31:0] rows [16] = '{
        32'h0001007F, 32'h0102017E, 32'h02042258, 32'h03086220,
        32'h0401007F, 32'h0501007F, 32'h0601007F, 32'h0701007F,
        32'h1001007F, 32'h1101007F, 32'h1201007F, 32'h1301007F,
        32'h1410017E, 32'h1520027C, 32'h16400278, 32'h1701007F};
    dfm_pin_mux dut_u (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hrdata, .hresp, .primary_flash_mode_pin, .secondary_flash_mode_pin,
        .boot_select_0, .boot_select_1, .dbg_pin_in, .dbg_pin_out, .dbg_pin_oe, .gpio_out,
        .gpio_oe, .gpio_in, .tool_select, .eng_data_out, .eng_data_oe, .eng_clk_out,
        .eng_ready, .eng_event, .eng_data_in, .eng_clk, .eng_clk_rise, .eng_tms, .eng_trst,
        .run_app, .flash_prog_en, .bscan_en, .active_if);
    dfm_tool_model tool_u (
        .strap_sel, .go, .tx_byte, .pad(dbg_pin_in), .primary(primary_flash_mode_pin),
        .secondary(secondary_flash_mode_pin), .boot0(boot_select_0), .boot1(boot_select_1),
        .tool_out, .tool_oe, .rx_byte, .busy);
    always #25 hclk = ~hclk;
    assign hready = hreadyout;
    // Undriven pads float up, so a released line never keeps its last level
    assign dbg_pin_in = (dbg_pin_oe & dbg_pin_out) | (~dbg_pin_oe & ~tool_oe)
                      | (~dbg_pin_oe & tool_oe & tool_out);
    // Engine answer toggles per received clock so the tool sees 0x55
    always @(posedge hclk) begin
        if (framing && eng_clk_rise) begin
            rises++;
            got <= {got[6:0], eng_data_in};
            eng_data_out <= ~eng_data_out;
        end
    end
    task automatic final_report();
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, wd, output logic [31:0] rd);
        int n;
        n = 0;
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 20);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 20);
        rd = hrdata;
        if (n >= 20) err_total++;
    endtask
    task automatic do_reset(input logic [1:0] m);
        strap_sel <= m;
        hresetn   <= 1'b0;
        tick(8);
        hresetn   <= 1'b1;
        tick(6);
    endtask
    task automatic frame(input logic [7:0] b);
        tx_byte      <= b;
        eng_data_out <= 1'b0;
        framing      <= 1'b1;
        go           <= 1'b1;
        rises = 0;
        tick(2);
        go <= 1'b0;
        for (int k = 0; k < 200 && busy; k++) tick(1);
        tick(4);
        framing <= 1'b0;
        `CHK("dev_rx", b, got)
        `CHK("rises", 8, rises)
        `CHK("tool_rx", 8'h55, rx_byte)
        `CHK("clk_idle", 1'b1, eng_clk)
    endtask
    initial begin
        do_reset(2'h0);
        for (int r = 0; r < 16; r++) begin
            if (rows[r][28] !== strap_sel[0]) do_reset({1'b0, rows[r][28]});
            tool_select <= rows[r][26:24];
            tick(3);
            `CHK("active_if", rows[r][22:16], active_if)
            `CHK("pad_oe", rows[r][14:8], dbg_pin_oe)
            `CHK("pad_out", rows[r][6:0], dbg_pin_out)
            `CHK("mode", {rows[r][28], ~rows[r][28]}, {flash_prog_en, run_app})
        end
        do_reset(2'h0);
        bus(1'b0, 32'h0, 32'h0, rdat);
        `CHK("ctrl", 32'h1, rdat)
        `CHK("resp", 2'b01, {hresp, hreadyout})
        tool_select <= 3'h3;
        eng_event   <= 1'b1;
        // Pad levels need mapping, two sync stages and the register edge
        tick(4);
        bus(1'b0, 32'h4, 32'h0, rdat);
        `CHK("status", 32'h007D0802, rdat)
        `CHK("nexus_in", 9'h003, {gpio_in, eng_tms, eng_trst})
        bus(1'b0, 32'h8, 32'h0, rdat);
        `CHK("unmapped", 32'h0, rdat)
        bus(1'b1, 32'h0, 32'h0, rdat);
        tick(2);
        `CHK("gated", 7'h01, active_if)
        bus(1'b1, 32'h0, 32'h1, rdat);
        tool_select <= 3'h2;
        eng_clk_out <= 1'b1;
        tick(3);
        `CHK("clk_out", 1'b1, dbg_pin_out[5])
        frame(8'hA5);
        strap_sel <= 2'h1;
        tick(6);
        `CHK("held", 2'b01, {flash_prog_en, run_app})
        do_reset(2'h1);
        tool_select <= 3'h6;
        tick(3);
        frame(8'h3C);
        for (int m = 2; m < 4; m++) begin
            do_reset(m[1:0]);
            tool_select <= 3'h4;
            tick(3);
            `CHK("scan_mode", {2'b00, m == 2}, {run_app, flash_prog_en, bscan_en})
            `CHK("scan_if", 7'h01, active_if)
        end
        gpio_oe  <= 7'h7F;
        gpio_out <= 7'h2A;
        tick(5);
        `CHK("gpio_pad", 7'h2A, dbg_pin_out)
        `CHK("gpio_in", 7'h2A, gpio_in)
        final_report();
    end
    initial begin
        #100000;
        err_total++;
        final_report();
    end
endmodule // dfm_pin_mux_test
bind dfm_pin_mux dfm_pin_mux_props chk_u (
    .hclk, .hresetn, .dbg_pin_in, .dbg_pin_out, .dbg_pin_oe, .eng_data_out, .eng_data_oe,
    .eng_ready, .eng_event, .eng_data_in, .run_app, .flash_prog_en, .bscan_en, .active_if);
`default_nettype wire

// ### tb/dfm_tool_model.sv
// Behavioural debug or programming tool on the far side of the pad group.
// Assumes the bench resolves the pads with pull-ups and feeds them back.
`timescale 1ns/100ps
`default_nettype none
module dfm_tool_model (
    input  wire logic [1:0] strap_sel,
    input  wire logic       go,
    input  wire logic [7:0] tx_byte,
    input  wire logic [6:0] pad,
    output logic            primary,
    output logic            secondary,
    output logic            boot0,
    output logic            boot1,
    output logic [6:0]      tool_out,
    output logic [6:0]      tool_oe,
    output logic [7:0]      rx_byte,
    output logic            busy
);
    // Secondary strap is high for strap_sel 2 and 3; 3 also raises boot0, so it gives the reserved mode
    assign primary   = (strap_sel != 2'h0);
    assign secondary = strap_sel[1];
    assign boot0     = (strap_sel == 2'h3);
    assign boot1     = (strap_sel == 2'h2);
    initial begin
        tool_out = 7'h00;
        tool_oe  = 7'h00;
        rx_byte  = 8'h00;
        busy     = 1'b0;
    end
    // Clock and data are released between frames, so the clock stands high
    always @(posedge go) begin
        busy = 1'b1;
        #7;
        tool_oe = 7'h05;
        for (int i = 7; i >= 0; i--) begin
            tool_out[0] = tx_byte[i];
            tool_out[2] = 1'b0;
            #200;
            tool_out[2] = 1'b1;
            rx_byte = {rx_byte[6:0], pad[1]};
            #200;
        end
        tool_oe = 7'h00;
        busy = 1'b0;
    end
endmodule // dfm_tool_model
`default_nettype wire
